//--- hw/rio_pkg.sv
package rio_pkg;
    // clock period in ns
    localparam int CLK_PERIOD_NS = 100;
    // reset timing, ns and units
    localparam int RST_CYCLE_NS = 10000;
    localparam int RST_CYCLE_CLKS = RST_CYCLE_NS / CLK_PERIOD_NS;
    localparam int RST_DELAY_MIN = 20;
    localparam int RST_DELAY_MAX = 2000;
    localparam logic [10:0] RST_DELAY_DEFAULT = 11'h064;
    // interrupt timing, microseconds
    localparam int IRQ_LOW_MIN_US = 100;
    localparam int IRQ_HIGH_MIN_US = 300;
    localparam int IRQ_TIMEOUT_US = 300;
    localparam int IRQ_LOW_MIN_CLKS = IRQ_LOW_MIN_US * 1000 / CLK_PERIOD_NS;
    localparam int IRQ_HIGH_MIN_CLKS = IRQ_HIGH_MIN_US * 1000 / CLK_PERIOD_NS;
    localparam int IRQ_TIMEOUT_CLKS = IRQ_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int TIMER_W = 12;
    typedef enum logic [1:0] {RIO_IRQ_IDLE, RIO_IRQ_LOW, RIO_IRQ_HIGH_HOLD} rio_irq_state_type;
endpackage

//--- hw/rio_timer_if.sv
`timescale 1ns/1ns
interface rio_timer_if;
    logic restart;
    logic [rio_pkg::TIMER_W-1:0] count;
    modport owner(output restart, input count);
    modport timer(input restart, output count);
endinterface

//--- hw/rio_timer.sv
`timescale 1ns/1ns
// free-running saturating counter, restarted on line transitions
module rio_timer (
    input wire logic sys_clk,
    input wire logic resetn,
    rio_timer_if.timer tif
);
    logic [rio_pkg::TIMER_W-1:0] count_reg;
    assign tif.count = count_reg;
    always_ff @(posedge sys_clk) begin
        if (!resetn || tif.restart) begin
            count_reg <= '0;
        end else if (count_reg != '1) begin
            count_reg <= count_reg + 1'b1;
        end
    end
endmodule

//--- hw/rio_top.sv
`timescale 1ns/1ns
// Contract
// - any reset cause pulls reset low immediately
// - release after causes clear plus delay
// - supply out of band is reset cause
// - hard reset also turns supplies off
// - soft reset keeps supplies running
// - delay in 10us units, 20..2000
// - delay defaults to 100 units
// - newly set flag raises interrupt
// - single active-low push-pull interrupt line
// - all flags cleared returns line high
// - line held low minimum low time
// - minimum high time, pending interrupt waits
// - time-out drives line high
// - time-out sets missed interrupt flag
// - missed flag raises no interrupt
// - minimum low time 100us
// - time-out 300us, only line released
// - minimum high time 300us
module rio_top #(
    parameter int N_FLAGS = 8,
    parameter int N_CAUSES = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [N_CAUSES-1:0] hard_cause,
    input wire logic [N_CAUSES-1:0] soft_cause,
    input wire logic supply_out_of_band,
    input wire logic [10:0] reset_delay_units,
    input wire logic reset_delay_load,
    input wire logic [N_FLAGS-1:0] irq_flags,
    input wire logic missed_irq_clear,
    output logic mcu_reset_out_n_o,
    output logic mcu_reset_out_n_oe,
    output logic mcu_supply_en,
    output logic irq_n,
    output logic missed_irq_flag
);
    logic any_cause;
    logic [10:0] delay_reg;
    logic [10:0] unit_cnt_reg;
    logic [6:0] pre_cnt_reg;
    logic rst_active_reg;
    logic hard_reg;
    logic [N_FLAGS-1:0] flags_q_reg;
    logic new_flag;
    logic pending_reg;
    logic irq_n_reg;
    logic missed_reg;
    rio_pkg::rio_irq_state_type state_reg;
    rio_timer_if tif();
    localparam int TWI = rio_pkg::TIMER_W;
    typedef logic [TWI-1:0] TW;

    rio_timer u_timer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tif(tif)
    );

    assign any_cause = (|hard_cause) || (|soft_cause) || supply_out_of_band;
    // open drain: drive low only
    assign mcu_reset_out_n_o = 1'b0;
    assign mcu_reset_out_n_oe = any_cause || rst_active_reg;
    assign mcu_supply_en = !hard_reg;
    assign irq_n = irq_n_reg;
    assign missed_irq_flag = missed_reg;

    // delay setting, clamped to its range
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            delay_reg <= rio_pkg::RST_DELAY_DEFAULT;
        end else if (reset_delay_load) begin
            if (reset_delay_units < 11'(rio_pkg::RST_DELAY_MIN)) begin
                delay_reg <= 11'(rio_pkg::RST_DELAY_MIN);
            end else if (reset_delay_units > 11'(rio_pkg::RST_DELAY_MAX)) begin
                delay_reg <= 11'(rio_pkg::RST_DELAY_MAX);
            end else begin
                delay_reg <= reset_delay_units;
            end
        end
    end

    // reset hold and release
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rst_active_reg <= 1'b1;
            unit_cnt_reg <= '0;
            pre_cnt_reg <= '0;
        end else if (any_cause) begin
            rst_active_reg <= 1'b1;
            unit_cnt_reg <= '0;
            pre_cnt_reg <= '0;
        end else if (rst_active_reg) begin
            if (pre_cnt_reg == 7'(rio_pkg::RST_CYCLE_CLKS - 1)) begin
                pre_cnt_reg <= '0;
                if (unit_cnt_reg + 11'h001 >= delay_reg) begin
                    rst_active_reg <= 1'b0;
                end else begin
                    unit_cnt_reg <= unit_cnt_reg + 11'h001;
                end
            end else begin
                pre_cnt_reg <= pre_cnt_reg + 7'h01;
            end
        end
    end

    // hard reset keeps supplies off until release
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            hard_reg <= 1'b0;
        end else if (|hard_cause) begin
            hard_reg <= 1'b1;
        end else if (!rst_active_reg) begin
            hard_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            flags_q_reg <= '0;
        end else begin
            flags_q_reg <= irq_flags;
        end
    end
    assign new_flag = |(irq_flags & ~flags_q_reg);

    // interrupt line sequencing
    always_comb begin
        tif.restart = 1'b0;
        if (rst_active_reg || any_cause) begin
            tif.restart = 1'b1;
        end else begin
            case (state_reg)
                rio_pkg::RIO_IRQ_IDLE: tif.restart = new_flag || pending_reg;
                rio_pkg::RIO_IRQ_LOW: tif.restart =
                    (tif.count >= TW'(rio_pkg::IRQ_LOW_MIN_CLKS) && irq_flags == '0)
                    || tif.count >= TW'(rio_pkg::IRQ_TIMEOUT_CLKS - 1);
                default: tif.restart = 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn || rst_active_reg || any_cause) begin
            state_reg <= rio_pkg::RIO_IRQ_IDLE;
            irq_n_reg <= 1'b1;
            pending_reg <= 1'b0;
        end else begin
            case (state_reg)
                rio_pkg::RIO_IRQ_IDLE: begin
                    if (new_flag || pending_reg) begin
                        irq_n_reg <= 1'b0;
                        pending_reg <= 1'b0;
                        state_reg <= rio_pkg::RIO_IRQ_LOW;
                    end
                end
                rio_pkg::RIO_IRQ_LOW: begin
                    if (tif.restart) begin
                        irq_n_reg <= 1'b1;
                        state_reg <= rio_pkg::RIO_IRQ_HIGH_HOLD;
                    end
                    if (new_flag && tif.restart) begin
                        pending_reg <= 1'b1;
                    end
                end
                rio_pkg::RIO_IRQ_HIGH_HOLD: begin
                    if (new_flag) begin
                        pending_reg <= 1'b1;
                    end
                    if (tif.count >= TW'(rio_pkg::IRQ_HIGH_MIN_CLKS - 1)) begin
                        state_reg <= rio_pkg::RIO_IRQ_IDLE;
                    end
                end
                default: state_reg <= rio_pkg::RIO_IRQ_IDLE;
            endcase
        end
    end

    // missed flag: set wins over clear; no line assertion
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            missed_reg <= 1'b0;
        end else if (!rst_active_reg && !any_cause && state_reg == rio_pkg::RIO_IRQ_LOW
                     && tif.count >= TW'(rio_pkg::IRQ_TIMEOUT_CLKS - 1)) begin
            missed_reg <= 1'b1;
        end else if (missed_irq_clear) begin
            missed_reg <= 1'b0;
        end
    end

    // interval measurement for the line checks
    logic [TWI-1:0] low_len_reg;
    logic [TWI-1:0] high_len_reg;

    always_ff @(posedge sys_clk) begin
        if (!resetn || rst_active_reg || any_cause) begin
            low_len_reg <= '0;
        end else if (irq_n) begin
            low_len_reg <= '0;
        end else if (low_len_reg != '1) begin
            low_len_reg <= low_len_reg + 1'b1;
        end
    end

    // saturated after reset: first interrupt is not held back
    always_ff @(posedge sys_clk) begin
        if (!resetn || rst_active_reg || any_cause) begin
            high_len_reg <= '1;
        end else if (!irq_n) begin
            high_len_reg <= '0;
        end else if (high_len_reg != '1) begin
            high_len_reg <= high_len_reg + 1'b1;
        end
    end

    // assertions
    low_len_a: assert property (@(posedge sys_clk) disable iff (!resetn || rst_active_reg
        || any_cause) $rose(irq_n) |-> low_len_reg >= TW'(rio_pkg::IRQ_LOW_MIN_CLKS))
        else $error("low time below minimum");
    timeout_len_a: assert property (@(posedge sys_clk) disable iff (!resetn || rst_active_reg
        || any_cause) !irq_n |-> low_len_reg <= TW'(rio_pkg::IRQ_TIMEOUT_CLKS))
        else $error("low time beyond time-out");
    high_len_a: assert property (@(posedge sys_clk) disable iff (!resetn || rst_active_reg
        || any_cause) $fell(irq_n) |-> high_len_reg >= TW'(rio_pkg::IRQ_HIGH_MIN_CLKS))
        else $error("high time below minimum");
    cause_pulls_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        any_cause |-> mcu_reset_out_n_oe) else $error("reset not pulled");
    release_delay_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (rst_active_reg && any_cause) |=> rst_active_reg) else $error("early release");
    supply_band_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        supply_out_of_band |=> rst_active_reg) else $error("band not reset");
    hard_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (|hard_cause) |=> !mcu_supply_en) else $error("supply on in hard reset");
    soft_on_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!hard_reg && !(|hard_cause)) |=> mcu_supply_en) else $error("supply off");
    delay_range_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        delay_reg >= 11'(rio_pkg::RST_DELAY_MIN) && delay_reg <= 11'(rio_pkg::RST_DELAY_MAX))
        else $error("delay out of range");
    min_low_a: assert property (@(posedge sys_clk) disable iff (!resetn || rst_active_reg
        || any_cause) $fell(irq_n) |-> !irq_n [*8]) else $error("low too short");
    high_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn || rst_active_reg
        || any_cause) $rose(irq_n) |-> irq_n [*8]) else $error("high too short");
    reset_high_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rst_active_reg |=> irq_n) else $error("irq low in reset");
    missed_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(missed_reg) |-> irq_n) else $error("missed raised line");
    irq_c: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(irq_n));
    miss_c: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(missed_reg));
    release_c: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(rst_active_reg));
    pending_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        state_reg == rio_pkg::RIO_IRQ_HIGH_HOLD && new_flag);
endmodule

//--- verif/rio_mcu_model.sv
`timescale 1ns/1ns
// microcontroller side: owns the flag bits, clears them over its serial link
module rio_mcu_model #(
    parameter int N_FLAGS = 8
) (
    input wire logic sys_clk,
    input wire logic [N_FLAGS-1:0] set_req,
    input wire logic service_en,
    input wire logic poll,
    input wire logic missed_irq_flag,
    output logic [N_FLAGS-1:0] irq_flags,
    output logic missed_irq_clear
);
    int svc_cnt = 0;
    initial irq_flags = '0;
    initial missed_irq_clear = 1'b0;
    // service clears the flags on the 21st cycle once enabled
    always @(posedge sys_clk) begin
        svc_cnt <= (service_en && irq_flags != '0 && svc_cnt < 20) ? svc_cnt + 1 : 0;
        irq_flags <= (svc_cnt == 20) ? '0 : (irq_flags | set_req);
        missed_irq_clear <= poll & missed_irq_flag;
    end
endmodule

//--- verif/rio_top_tb_top.sv
`timescale 1ns/1ns
module rio_top_tb_top;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] hard_cause = 4'h0;
    logic [3:0] soft_cause = 4'h0;
    logic supply_out_of_band = 1'b0;
    logic [10:0] reset_delay_units = 11'h000;
    logic reset_delay_load = 1'b0;
    logic [7:0] set_req = 8'h00;
    logic service_en = 1'b0;
    logic poll = 1'b0;
    logic [7:0] irq_flags;
    logic missed_irq_clear, rst_o, rst_oe, supply_en, irq_n, missed;
    wire reset_line = rst_oe ? rst_o : 1'b1;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #50 sys_clk = ~sys_clk;
    rio_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .hard_cause(hard_cause),
        .soft_cause(soft_cause), .supply_out_of_band(supply_out_of_band),
        .reset_delay_units(reset_delay_units), .reset_delay_load(reset_delay_load),
        .irq_flags(irq_flags), .missed_irq_clear(missed_irq_clear),
        .mcu_reset_out_n_o(rst_o), .mcu_reset_out_n_oe(rst_oe), .mcu_supply_en(supply_en),
        .irq_n(irq_n), .missed_irq_flag(missed));
    rio_mcu_model i_mcu (.sys_clk(sys_clk), .set_req(set_req), .service_en(service_en),
        .poll(poll), .missed_irq_flag(missed), .irq_flags(irq_flags),
        .missed_irq_clear(missed_irq_clear));
    task end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail = n_fail + 1;
            end_of_test;
        end
    end
    task chk(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %b seen %b", name, exp, got);
            n_fail++;
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task pulse_flag(input logic [7:0] v, input logic svc);
        @(posedge sys_clk);
        set_req <= v;
        service_en <= svc;
        @(posedge sys_clk);
        set_req <= 8'h00;
        #1;
    endtask
    task test_boot;
        step(9900);
        chk("reset_oe", 1'b1, rst_oe);
        step(200);
        chk("reset_oe", 1'b0, rst_oe);
        chk("reset_line", 1'b1, reset_line);
    endtask
    task test_irq;
        pulse_flag(8'h01, 1'b1);
        step(2);
        chk("irq_n", 1'b0, irq_n);
        step(800);
        chk("irq_n", 1'b0, irq_n);
        step(300);
        chk("irq_n", 1'b1, irq_n);
        pulse_flag(8'h02, 1'b0);
        step(2600);
        chk("irq_n", 1'b1, irq_n);
        step(500);
        chk("irq_n", 1'b0, irq_n);
        pulse_flag(8'h00, 1'b1);
        step(1000);
        chk("irq_n", 1'b1, irq_n);
        step(3100);
    endtask
    task test_timeout;
        pulse_flag(8'h04, 1'b0);
        step(2800);
        chk("irq_n", 1'b0, irq_n);
        chk("missed", 1'b0, missed);
        step(300);
        chk("irq_n", 1'b1, irq_n);
        chk("missed", 1'b1, missed);
        step(2800);
        chk("irq_n", 1'b1, irq_n);
        @(posedge sys_clk) poll <= 1'b1;
        step(3);
        chk("missed", 1'b0, missed);
        @(posedge sys_clk) poll <= 1'b0;
        pulse_flag(8'h00, 1'b1);
        step(30);
    endtask
    task test_causes;
        @(posedge sys_clk) reset_delay_units <= 11'h005;
        reset_delay_load <= 1'b1;
        @(posedge sys_clk) reset_delay_load <= 1'b0;
        @(posedge sys_clk) soft_cause <= 4'h2;
        #1;
        chk("reset_oe", 1'b1, rst_oe);
        chk("supply_en", 1'b1, supply_en);
        step(10);
        @(posedge sys_clk) soft_cause <= 4'h0;
        step(1900);
        chk("reset_oe", 1'b1, rst_oe);
        step(200);
        chk("reset_oe", 1'b0, rst_oe);
        @(posedge sys_clk) hard_cause <= 4'h1;
        step(2);
        chk("reset_oe", 1'b1, rst_oe);
        chk("supply_en", 1'b0, supply_en);
        @(posedge sys_clk) hard_cause <= 4'h0;
        step(2200);
        chk("supply_en", 1'b1, supply_en);
        @(posedge sys_clk) supply_out_of_band <= 1'b1;
        #1;
        chk("reset_oe", 1'b1, rst_oe);
        pulse_flag(8'h08, 1'b0);
        step(5);
        chk("irq_n", 1'b1, irq_n);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        test_boot;
        test_irq;
        test_timeout;
        test_causes;
        end_of_test;
    end
endmodule
